// ===== fld_cdi_properties.sv
// Purpose: Port-level checks on the forward link command dispatch block.
// Assumes: One clock domain and a synchronous active-low reset.
// Notes:   Bound to the design module after the checker.
module fld_link_properties (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire fld_pkg::fld_mode_type mode,
  input wire logic                  spc_ser_vld,
  input wire logic [255:0]          disc_pulse,
  input wire logic                  peer_power_off,
  input wire logic                  sci_vld,
  input wire logic                  cfg_vld,
  input wire logic                  rec_vld,
  input wire logic                  rtc_cpu_vld,
  input wire logic                  rtc_unit_vld,
  input wire logic                  blk_vld,
  input wire logic [47:0]           dec_msg,
  input wire logic                  in_sync,
  input wire logic                  msg_reject,
  input wire logic                  bad_opcode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Local dispatch strobes and decoder class strobes, gathered so each path check stays short.
  wire logic loc_any = spc_ser_vld | sci_vld | (|disc_pulse);
  wire logic cls_any = cfg_vld | rec_vld | rtc_cpu_vld | rtc_unit_vld | blk_vld;
  //////////////////////////////////////////////////////////////////////////////
  a_sync_first: assert property (!in_sync |-> !(loc_any | cls_any | msg_reject))
    else $error("command output before sync");
  a_sync_kept: assert property (in_sync |=> in_sync)
    else $error("sync lost without reset");
  a_one_path: assert property (loc_any |-> $onehot({spc_ser_vld, sci_vld, |disc_pulse}) && !msg_reject)
    else $error("message left on two paths");
  a_disc_onehot: assert property (|disc_pulse |-> $onehot(disc_pulse))
    else $error("more than one discrete pulsed");
  a_pwr_cause: assert property ($rose(peer_power_off) |->
      disc_pulse[fld_pkg::DISC_PWR_OFF] || $past(disc_pulse[fld_pkg::DISC_PWR_OFF]))
    else $error("peer power off without its discrete");
  a_pwr_sticky: assert property (peer_power_off |=> peer_power_off)
    else $error("peer power off dropped");
  a_reject_only: assert property (msg_reject |-> !loc_any ##1 !cls_any)
    else $error("rejected message produced output");
  a_class_single: assert property ((cls_any | bad_opcode) |->
      $onehot({cls_any, bad_opcode}) && $onehot0({cfg_vld, rec_vld, rtc_cpu_vld, rtc_unit_vld, blk_vld}))
    else $error("decoder raised two classes");
  a_class_opcode: assert property (cls_any |-> dec_msg[fld_pkg::OPC_MSB:fld_pkg::OPC_LSB] ==
      (cfg_vld ? fld_pkg::OP_CFG : rec_vld ? fld_pkg::OP_REC : blk_vld ? fld_pkg::OP_BLK : fld_pkg::OP_RTC))
    else $error("class strobe does not match opcode");
  a_rtc_cpu: assert property (rtc_cpu_vld |-> mode == fld_pkg::MODE_NORMAL)
    else $error("real-time command to computer outside normal mode");
  a_rtc_unit: assert property (rtc_unit_vld |-> mode != fld_pkg::MODE_NORMAL)
    else $error("real-time command bypassed computer in normal mode");
  c_unit: cover property (rtc_unit_vld);
  c_power: cover property ($rose(peer_power_off));
  c_reject: cover property (msg_reject);
endmodule

bind fld_command_data_interface fld_link_properties u_props (
  .core_clk(core_clk), .rst_n(rst_n), .mode(mode), .spc_ser_vld(spc_ser_vld), .disc_pulse(disc_pulse),
  .peer_power_off(peer_power_off), .sci_vld(sci_vld), .cfg_vld(cfg_vld), .rec_vld(rec_vld),
  .rtc_cpu_vld(rtc_cpu_vld), .rtc_unit_vld(rtc_unit_vld), .blk_vld(blk_vld), .dec_msg(dec_msg),
  .in_sync(in_sync), .msg_reject(msg_reject), .bad_opcode(bad_opcode)
);

// ===== fld_command_data_interface.sv
// Purpose: Forward link command path: sync hunt, message receive, check, dispatch.
// Assumes: link_bit and link_bit_stb are synchronous to another clock; strobe lasts >= 2 cycles per bit edge.
// Notes:   Serial outputs are parallel words with a strobe; a line serialiser sits outside.
// Function
// - Accept 48-bit forward link messages from the transponder.
// - Check spacecraft address and polycode; only passing messages continue.
// - Each valid message goes to exactly one path.
// - Special commands run locally as 16-bit serial or discrete commands.
// - Provide 256 discrete outputs, 18 used inside the hub.
// - Special serial commands go to transponder, array drive, safe-mode electronics.
// - Science handler commands leave as 27-bit words.
// - Decoder decodes opcode and acts only on valid messages.
// - Decoder separates config, recorder, real-time and computer block messages.
// - Normal mode: real-time commands go under flight computer control.
// - Bypass mode: real-time commands go straight to unit interface module.
// - Either redundant interface can power off the other on ground command.
// - Diagnostic mode routes real-time commands like bypass mode.
module fld_command_data_interface (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   link_bit,
  input  wire logic                   link_bit_stb,
  input  wire fld_pkg::fld_mode_type  mode,
  output logic                        spc_ser_vld,
  output logic [1:0]                  spc_ser_dst,
  output logic [15:0]                 spc_ser_word,
  output logic [255:0]                disc_pulse,
  output logic                        peer_power_off,
  output logic                        sci_vld,
  output logic [26:0]                 sci_word,
  output logic                        cfg_vld,
  output logic                        rec_vld,
  output logic                        rtc_cpu_vld,
  output logic                        rtc_unit_vld,
  output logic                        blk_vld,
  output logic [47:0]                 dec_msg,
  output logic                        in_sync,
  output logic                        msg_reject,
  output logic                        bad_opcode
);

  typedef enum logic [1:0] {
    ST_HUNT  = 2'b00,
    ST_RECV  = 2'b01,
    ST_CHECK = 2'b10
  } fld_state_type;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: the bit and strobe come from the transponder's domain.
  logic [1:0] bit_s_r, stb_s_r;
  logic       stb_d_r;
  logic       stb_rise;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bit_s_r <= 2'b00;
      stb_s_r <= 2'b00;
      stb_d_r <= 1'b0;
    end else begin
      bit_s_r <= {bit_s_r[0], link_bit};
      stb_s_r <= {stb_s_r[0], link_bit_stb};
      stb_d_r <= stb_s_r[1];
    end
  end

  // Only the second stage feeds the edge detector.
  assign stb_rise = stb_s_r[1] && !stb_d_r;

  //////////////////////////////////////////////////////////////////////////////
  // Receive state: shift register and bit counter.
  fld_state_type st_r, st_nxt;
  logic [47:0]   sh_r, sh_nxt;
  logic [5:0]    cnt_r, cnt_nxt;
  logic [7:0]    poly;
  logic          msg_ok;

  // Simple XOR-fold check over the five bytes above the polycode field, address included, stands in for the polycode.
  function automatic logic [7:0] poly_calc(input logic [47:0] m);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 1; i < 6; i++) begin
      p = p ^ m[i*8 +: 8];
    end
    return p;
  endfunction

  assign poly   = poly_calc(sh_r);
  // Both checks must pass before anything other than msg_reject is emitted.
  assign msg_ok = (sh_r[fld_pkg::ADDR_MSB:fld_pkg::ADDR_LSB] == fld_pkg::SC_ADDR) &&
                  (sh_r[fld_pkg::POLY_MSB:fld_pkg::POLY_LSB] == poly);

  // Sync hunt, then counted message reception; stays in sync for later messages.
  always_comb begin
    st_nxt  = st_r;
    sh_nxt  = sh_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      ST_HUNT: begin
        if (stb_rise) begin
          sh_nxt = {sh_r[46:0], bit_s_r[1]};
          if ({sh_r[30:0], bit_s_r[1]} == fld_pkg::SYNC_WORD) begin
            st_nxt  = ST_RECV;
            cnt_nxt = 6'h00;
          end
        end
      end
      ST_RECV: begin
        if (stb_rise) begin
          sh_nxt  = {sh_r[46:0], bit_s_r[1]};
          cnt_nxt = 6'(cnt_r + 6'h01);
          if (cnt_r == 6'(fld_pkg::MSG_W - 1)) begin
            st_nxt = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        st_nxt  = ST_RECV;
        cnt_nxt = 6'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r  <= ST_HUNT;
      sh_r  <= 48'h0;
      cnt_r <= 6'h00;
    end else begin
      st_r  <= st_nxt;
      sh_r  <= sh_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Dispatch: one pulse-wide output per checked message.
  logic         chk;
  logic         ser_r, ser_nxt, sci_r, sci_nxt, fwd, rej_r, rej_nxt, pwr_r, pwr_nxt;
  logic [1:0]   dst_r, dst_nxt;
  logic [15:0]  sw_r, sw_nxt;
  logic [26:0]  sciw_r, sciw_nxt;
  logic [255:0] disc_r, disc_nxt;
  logic [7:0]   disc_idx;
  logic [1:0]   route;

  assign chk     = (st_r == ST_CHECK);
  assign route   = sh_r[fld_pkg::ROUTE_MSB:fld_pkg::ROUTE_LSB];
  assign disc_idx = sh_r[fld_pkg::DISC_MSB:fld_pkg::DISC_LSB];
  // Only this one path is pushed into the decoder.
  assign fwd     = chk && msg_ok && (route == fld_pkg::RT_DEC);

  always_comb begin
    ser_nxt  = 1'b0;
    sci_nxt  = 1'b0;
    rej_nxt  = 1'b0;
    pwr_nxt  = pwr_r;
    disc_nxt = '0;
    dst_nxt  = dst_r;
    sw_nxt   = sw_r;
    sciw_nxt = sciw_r;
    if (chk) begin
      if (!msg_ok) begin
        rej_nxt = 1'b1;
      end else begin
        unique case (route)
          fld_pkg::RT_SPC_SER: begin
            ser_nxt = 1'b1;
            dst_nxt = sh_r[fld_pkg::DST_MSB:fld_pkg::DST_LSB];
            sw_nxt  = sh_r[fld_pkg::SPCW_MSB:fld_pkg::SPCW_LSB];
          end
          fld_pkg::RT_SPC_DISC: begin
            disc_nxt[disc_idx] = 1'b1;
            // Latched so the other interface stays off after the pulse.
            if (disc_idx == fld_pkg::DISC_PWR_OFF) begin
              pwr_nxt = 1'b1;
            end
          end
          fld_pkg::RT_SCI: begin
            sci_nxt  = 1'b1;
            sciw_nxt = sh_r[fld_pkg::SCIW_MSB:fld_pkg::SCIW_LSB];
          end
          fld_pkg::RT_DEC: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ser_r  <= 1'b0;
      sci_r  <= 1'b0;
      rej_r  <= 1'b0;
      pwr_r  <= 1'b0;
      disc_r <= '0;
      dst_r  <= 2'h0;
      sw_r   <= 16'h0000;
      sciw_r <= 27'h0000000;
    end else begin
      ser_r  <= ser_nxt;
      sci_r  <= sci_nxt;
      rej_r  <= rej_nxt;
      pwr_r  <= pwr_nxt;
      disc_r <= disc_nxt;
      dst_r  <= dst_nxt;
      sw_r   <= sw_nxt;
      sciw_r <= sciw_nxt;
    end
  end

  fld_decoder u_dec (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .msg_vld      (fwd),
    .msg          (sh_r),
    .mode         (mode),
    .cfg_vld      (cfg_vld),
    .rec_vld      (rec_vld),
    .rtc_cpu_vld  (rtc_cpu_vld),
    .rtc_unit_vld (rtc_unit_vld),
    .blk_vld      (blk_vld),
    .bad_opc      (bad_opcode),
    .dec_msg      (dec_msg)
  );

  assign spc_ser_vld    = ser_r;
  assign spc_ser_dst    = dst_r;
  assign spc_ser_word   = sw_r;
  assign disc_pulse     = disc_r;
  assign peer_power_off = pwr_r;
  assign sci_vld        = sci_r;
  assign sci_word       = sciw_r;
  assign in_sync        = (st_r != ST_HUNT);
  assign msg_reject     = rej_r;

endmodule

// ===== fld_decoder.sv
// Purpose: Command decoder stage: classify forwarded messages by opcode.
// Assumes: Input strobe comes from the interface stage on the same clock.
// Notes:   Unknown opcodes are dropped and flagged as invalid on bad_opc.
module fld_decoder (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   msg_vld,
  input  wire logic [47:0]            msg,
  input  wire fld_pkg::fld_mode_type  mode,
  output logic                        cfg_vld,
  output logic                        rec_vld,
  output logic                        rtc_cpu_vld,
  output logic                        rtc_unit_vld,
  output logic                        blk_vld,
  output logic                        bad_opc,
  output logic [47:0]                 dec_msg
);

  logic        cfg_r, rec_r, rcpu_r, runit_r, blk_r, bad_r;
  logic        cfg_nxt, rec_nxt, rcpu_nxt, runit_nxt, blk_nxt, bad_nxt;
  logic [47:0] msg_r, msg_nxt;
  logic        direct;

  // Bypass and diagnostic both send real-time commands straight out.
  assign direct = (mode == fld_pkg::MODE_BYPASS) || (mode == fld_pkg::MODE_DIAG);

  // Opcode decode; one class strobe, or bad_opc for an unknown opcode, per valid message.
  always_comb begin
    cfg_nxt   = 1'b0;
    rec_nxt   = 1'b0;
    rcpu_nxt  = 1'b0;
    runit_nxt = 1'b0;
    blk_nxt   = 1'b0;
    bad_nxt   = 1'b0;
    msg_nxt   = msg_r;
    if (msg_vld) begin
      msg_nxt = msg;
      unique case (msg[fld_pkg::OPC_MSB:fld_pkg::OPC_LSB])
        fld_pkg::OP_CFG: cfg_nxt = 1'b1;
        fld_pkg::OP_REC: rec_nxt = 1'b1;
        fld_pkg::OP_RTC: begin
          runit_nxt = direct;
          rcpu_nxt  = !direct;
        end
        fld_pkg::OP_BLK: blk_nxt = 1'b1;
        default:         bad_nxt = 1'b1;
      endcase
    end
  end

  // Output registers.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_r   <= 1'b0;
      rec_r   <= 1'b0;
      rcpu_r  <= 1'b0;
      runit_r <= 1'b0;
      blk_r   <= 1'b0;
      bad_r   <= 1'b0;
      msg_r   <= 48'h0;
    end else begin
      cfg_r   <= cfg_nxt;
      rec_r   <= rec_nxt;
      rcpu_r  <= rcpu_nxt;
      runit_r <= runit_nxt;
      blk_r   <= blk_nxt;
      bad_r   <= bad_nxt;
      msg_r   <= msg_nxt;
    end
  end

  assign cfg_vld      = cfg_r;
  assign rec_vld      = rec_r;
  assign rtc_cpu_vld  = rcpu_r;
  assign rtc_unit_vld = runit_r;
  assign blk_vld      = blk_r;
  assign bad_opc      = bad_r;
  assign dec_msg      = msg_r;

endmodule

// ===== fld_ground_sender.sv
// Purpose: Ground sender seen through the transponder: bit and strobe lines.
// Assumes: Strobe levels last four clock cycles, above the two the block needs.
// Notes:   The strobe stands still low between frames.
module fld_ground_sender (
  input wire logic core_clk,
  output logic     link_bit,
  output logic     link_bit_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_bit = 1'b0;
    link_bit_stb = 1'b0;
  end
  // Sends 48 bits high bit first; the data line is inverted after the frame so stale bits never pass.
  task automatic send(input logic [47:0] val);
    for (int i = 47; i >= 0; i--) begin
      @(posedge core_clk);
      link_bit <= val[i];
      link_bit_stb <= 1'b0;
      repeat (4) @(posedge core_clk);
      link_bit_stb <= 1'b1;
      repeat (3) @(posedge core_clk);
    end
    @(posedge core_clk);
    link_bit_stb <= 1'b0;
    link_bit <= ~val[0];
  endtask
endmodule

// ===== fld_pkg.sv
// Purpose: Shared constants for the forward link command dispatch block.
// Assumes: 48-bit messages arrive as a serial bit stream with a bit strobe.
// Notes:   Field layout and code values are local choices; sync word is a parameter.
package fld_pkg;

  localparam int MSG_W           = 48;
  localparam int SPC_W           = 16;
  localparam int SCI_W           = 27;
  localparam int DISC_N          = 256;
  localparam int DISC_INT_N      = 18;
  localparam int CNT_W           = 6;

  // Message field layout, high bit first on the wire.
  localparam int ADDR_MSB        = 47;
  localparam int ADDR_LSB        = 40;
  localparam int ROUTE_MSB       = 39;
  localparam int ROUTE_LSB       = 38;
  localparam int OPC_MSB         = 37;
  localparam int OPC_LSB         = 35;
  localparam int POLY_MSB        = 7;
  localparam int POLY_LSB        = 0;
  localparam int DISC_MSB        = 15;
  localparam int DISC_LSB        = 8;
  localparam int DST_MSB         = 33;
  localparam int DST_LSB         = 32;
  localparam int SPCW_MSB        = 23;
  localparam int SPCW_LSB        = 8;
  localparam int SCIW_MSB        = 34;
  localparam int SCIW_LSB        = 8;

  // Address and sync pattern are arbitrary local values.
  localparam logic [7:0]  SC_ADDR    = 8'hA5;
  localparam logic [31:0] SYNC_WORD  = 32'hEB90_1ACF;

  // Route field codes.
  localparam logic [1:0] RT_SPC_SER  = 2'h0;
  localparam logic [1:0] RT_SPC_DISC = 2'h1;
  localparam logic [1:0] RT_SCI      = 2'h2;
  localparam logic [1:0] RT_DEC      = 2'h3;

  // Decoder opcodes.
  localparam logic [2:0] OP_CFG      = 3'h0;
  localparam logic [2:0] OP_REC      = 3'h1;
  localparam logic [2:0] OP_RTC      = 3'h2;
  localparam logic [2:0] OP_BLK      = 3'h3;

  // Special serial destinations.
  localparam logic [1:0] DST_XPDR    = 2'h0;
  localparam logic [1:0] DST_ARRAY   = 2'h1;
  localparam logic [1:0] DST_SAFE    = 2'h2;

  localparam logic [7:0] DISC_PWR_OFF = 8'h11;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_BYPASS = 2'b01,
    MODE_DIAG   = 2'b10
  } fld_mode_type;

endpackage

// ===== forward_link_command_dispatch_tb_top.sv
// Purpose: Self-checking bench for the command data interface.
// Assumes: Pulses are collected by a monitor, so exact output latency is not needed.
// Notes:   Sync is sent as a 48-bit unit with sixteen leading zeros.
module forward_link_command_dispatch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] F_SPC = 10'h001, F_DSC = 10'h002, F_SCI = 10'h004, F_CFG = 10'h008, F_REC = 10'h010;
  localparam logic [9:0] F_CPU = 10'h020, F_UNIT = 10'h040, F_BLK = 10'h080, F_REJ = 10'h100, F_BAD = 10'h200;
  logic                  core_clk, rst_n, link_bit, link_bit_stb, clr;
  fld_pkg::fld_mode_type mode;
  logic                  spc_ser_vld, peer_power_off, sci_vld, cfg_vld, rec_vld, rtc_cpu_vld, rtc_unit_vld;
  logic                  blk_vld, in_sync, msg_reject, bad_opcode;
  logic [1:0]            spc_ser_dst;
  logic [15:0]           spc_ser_word;
  logic [26:0]           sci_word;
  logic [47:0]           dec_msg;
  logic [255:0]          disc_pulse, disc_seen;
  logic [9:0]            seen;
  int                    npulse, bad_count, n_checks;
  wire logic [9:0] flags = {bad_opcode, msg_reject, blk_vld, rtc_unit_vld, rtc_cpu_vld, rec_vld, cfg_vld, sci_vld,
                            |disc_pulse, spc_ser_vld};

  fld_ground_sender u_gnd (.core_clk(core_clk), .link_bit(link_bit), .link_bit_stb(link_bit_stb));
  fld_command_data_interface dut (
    .core_clk(core_clk), .rst_n(rst_n), .link_bit(link_bit), .link_bit_stb(link_bit_stb), .mode(mode),
    .spc_ser_vld(spc_ser_vld), .spc_ser_dst(spc_ser_dst), .spc_ser_word(spc_ser_word), .disc_pulse(disc_pulse),
    .peer_power_off(peer_power_off), .sci_vld(sci_vld), .sci_word(sci_word), .cfg_vld(cfg_vld),
    .rec_vld(rec_vld), .rtc_cpu_vld(rtc_cpu_vld), .rtc_unit_vld(rtc_unit_vld), .blk_vld(blk_vld),
    .dec_msg(dec_msg), .in_sync(in_sync), .msg_reject(msg_reject), .bad_opcode(bad_opcode)
  );
  //////////////////////////////////////////////////////////////////////////////
  // Clock source and a monitor that gathers every pulse between clears.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    seen <= clr ? 10'h000 : seen | flags;
    disc_seen <= clr ? '0 : disc_seen | disc_pulse;
    npulse <= clr ? 0 : npulse + $countones(flags);
  end
  // Builds a message with a correct polycode unless the caller spoils it.
  function automatic logic [47:0] mk(input logic [1:0] rt, input logic [2:0] op, input logic [26:0] body,
                                     input logic [7:0] adr);
    logic [47:0] m;
    m = {adr, rt, op, body, 8'h00};
    m[7:0] = m[47:40] ^ m[39:32] ^ m[31:24] ^ m[23:16] ^ m[15:8];
    return m;
  endfunction
  task automatic chk_flags(input logic [9:0] exp);
    n_checks++;
    if (seen !== exp || npulse != $countones(exp)) begin
      bad_count++;
      $display("MISMATCH t=%0t pulses %h count %0d expected %h", $time, seen, npulse, exp);
    end
  endtask
  task automatic chk_word(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  // Clears the monitor, sends one message and lets the slowest path finish before judging.
  task automatic run(input logic [47:0] m, input logic [9:0] exp);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    u_gnd.send(m);
    repeat (12) @(posedge core_clk);
    chk_flags(exp);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_sync();
    run(mk(fld_pkg::RT_SCI, 3'h0, 27'h1, fld_pkg::SC_ADDR), 10'h000);
    chk_word({47'h0, in_sync}, 48'h0);
    run({16'h0000, fld_pkg::SYNC_WORD}, 10'h000);
    chk_word({47'h0, in_sync}, 48'h1);
    $display("test sync done");
  endtask
  task automatic t_special();
    logic [7:0]  ids [3];
    logic [15:0] w;
    ids = '{8'h00, 8'hFF, fld_pkg::DISC_PWR_OFF};
    for (int d = 0; d < 3; d++) begin
      w = 16'hC3A5 ^ d[15:0];
      run(mk(fld_pkg::RT_SPC_SER, 3'h0, {1'b0, d[1:0], 8'h00, w}, fld_pkg::SC_ADDR), F_SPC);
      chk_word({30'h0, spc_ser_dst, spc_ser_word}, {30'h0, d[1:0], w});
      run(mk(fld_pkg::RT_SPC_DISC, 3'h0, {19'h0, ids[d]}, fld_pkg::SC_ADDR), F_DSC);
      chk_word({46'h0, disc_seen[ids[d]], peer_power_off}, {46'h0, 1'b1, d == 2});
    end
    $display("test special done");
  endtask
  task automatic t_sci_reject();
    run(mk(fld_pkg::RT_SCI, 3'h0, 27'h7FFFFFF, fld_pkg::SC_ADDR), F_SCI);
    chk_word({21'h0, sci_word}, {21'h0, 27'h7FFFFFF});
    run(mk(fld_pkg::RT_SCI, 3'h0, 27'h1, 8'h5A), F_REJ);
    run(mk(fld_pkg::RT_SCI, 3'h0, 27'h1, fld_pkg::SC_ADDR) ^ 48'h1, F_REJ);
    $display("test science and reject done");
  endtask
  task automatic t_decoder();
    logic [9:0]  tab [5];
    logic [47:0] m;
    tab = '{F_CFG, F_REC, F_CPU, F_BLK, F_BAD};
    for (int md = 0; md < 3; md++) begin
      @(posedge core_clk);
      mode <= fld_pkg::fld_mode_type'(md[1:0]);
      for (int op = 0; op < 5; op++) begin
        m = mk(fld_pkg::RT_DEC, op[2:0], 27'h2A5A5A ^ op[26:0], fld_pkg::SC_ADDR);
        run(m, (op == 2 && md != 0) ? F_UNIT : tab[op]);
        if (op < 4) chk_word(dec_msg, m);
      end
    end
    $display("test decoder done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence; a second reset at the end must clear the sticky power-off and the sync state.
  initial begin
    rst_n = 1'b0;
    mode = fld_pkg::MODE_NORMAL;
    clr = 1'b1;
    bad_count = 0;
    n_checks = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_sync();
    t_special();
    t_sci_reject();
    t_decoder();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk_word({46'h0, in_sync, peer_power_off}, 48'h0);
    rst_n <= 1'b1;
    test_done();
  end
  // Watchdog sized well above the roughly 10,400 cycles the tests need.
  initial begin
    #2_000_000;
    bad_count++;
    test_done();
  end
endmodule
